// file: rtl/srp_device.sv
/*
  Device end of the serial register port: 32 byte registers, instruction
  decode, auto address, bit order, pin mode, software reset.
  Assumes the link pins arrive asynchronously; sampled by clk.
*/
// Decided for this implementation: strobed register access and the register offsets.
// Notes on behaviour
// - Instruction byte first, then data phase.
// - Instruction top bit high means read.
// - Count field gives one to four bytes.
// - Low five bits start address; auto-advance.
// - Write lands at last bit of byte.
// - Host clock at most 15 MHz.
// - Sample rising edge, shift out falling.
// - Select high: outputs released, clock ignored.
// - Host holds select through whole cycle.
// - Register 0 bit 7 selects bidirectional pin.
// - Read data on dedicated or shared pin.
// - LSB first: shift low bits, address increments.
// - MSB first default: address decrements.
// - Address counter wraps at 1Fh and 00h.
// - Config bits act right after write.
// - Software reset clears all but register 0.
// - Host prefers single-byte config writes.
// - Mirror pattern restores config and resets.
// - Second write reprograms multiplier setting.
// - Two-pin read shifts bytes on dedicated pin.
// - Bit 5 of register 0 is reset.
`timescale 1ns/1ps
`include "srp_regs.svh"
module srp_device #(
  parameter int NREG = 32
) (
  input  wire logic clk,
  input  wire logic sys_rst,
  srp_if.dev        link,
  output logic [7:0] mult_cfg_q,
  output logic       bidir_q,
  output logic       lsb_first_q,
  output logic [7:0] reg_view_q
);
  // ============================================================
  // Synchronisers
  // Link edges arrive three clocks late; the host half period must cover it
  logic [1:0] sclk_s_q, sel_s_q, sdio_s_q;
  logic       sclk_d1_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sclk_s_q  <= 2'h0;
      sel_s_q   <= 2'h3;
      sdio_s_q  <= 2'h0;
      sclk_d1_q <= 1'b0;
    end else begin
      sclk_s_q  <= {sclk_s_q[0], link.sclk};
      sel_s_q   <= {sel_s_q[0], link.sel_n};
      sdio_s_q  <= {sdio_s_q[0], link.sdio};
      sclk_d1_q <= sclk_s_q[1];
    end
  end
  logic sel_n, rise, fall;
  assign sel_n = sel_s_q[1];
  assign rise  = ~sel_n & sclk_s_q[1] & ~sclk_d1_q;
  assign fall  = ~sel_n & ~sclk_s_q[1] & sclk_d1_q;

  // ============================================================
  // Cycle state
  srp_pkg::srp_dev_state_t state_q;
  logic [2:0] bit_q;
  logic [7:0] shift_q;
  logic       rd_q;
  logic [1:0] left_q;
  logic [4:0] addr_q;
  logic [7:0] regs_q [NREG];
  logic [7:0] cfg_q;
  logic [7:0] in_byte, out_byte;
  logic       byte_end;

  assign in_byte  = lsb_first_q ? {sdio_s_q[1], shift_q[7:1]}
                                : {shift_q[6:0], sdio_s_q[1]};
  assign byte_end = rise & (bit_q == 3'h7);
  assign out_byte = (addr_q == `SRP_CFG_ADDR) ? cfg_q : regs_q[addr_q];

  // Five-bit wrap comes free from the counter width
  function automatic logic [4:0] srp_next_addr(input logic [4:0] a, input logic inc);
    srp_next_addr = inc ? a + 5'h01 : a - 5'h01;
  endfunction

  // Order that applies to the next byte, including a config just written
  function automatic logic cfg_wr_lsbf();
    cfg_wr_lsbf = (!rd_q && addr_q == `SRP_CFG_ADDR) ? in_byte[`SRP_CFG_LSBF_BIT]
                                                    : lsb_first_q;
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst || sel_n) begin
      state_q <= srp_pkg::SRP_INS;
      bit_q   <= 3'h0;
      shift_q <= 8'h00;
      rd_q    <= 1'b0;
      left_q  <= 2'h0;
      addr_q  <= 5'h00;
    end else if (rise) begin
      bit_q   <= bit_q + 3'h1;
      shift_q <= in_byte;
      if (byte_end) begin
        case (state_q)
          srp_pkg::SRP_INS: begin
            rd_q    <= in_byte[`SRP_INS_DIR_BIT];
            left_q  <= in_byte[`SRP_INS_CNT_HI:`SRP_INS_CNT_LO];
            addr_q  <= in_byte[`SRP_INS_ADR_HI:`SRP_INS_ADR_LO];
            state_q <= srp_pkg::SRP_DATA;
          end
          srp_pkg::SRP_DATA: begin
            addr_q <= srp_next_addr(addr_q, cfg_wr_lsbf());
            if (left_q == 2'h0) begin
              state_q <= srp_pkg::SRP_DONE;
            end else begin
              left_q <= left_q - 2'h1;
            end
          end
          // Done absorbs clocks past the last byte until select rises
          default: begin
          end
        endcase
      end
    end
  end

  // ============================================================
  // Registers and write path
  // Write lands on the eighth rise of each data byte, not at frame end
  logic wr_now;
  assign wr_now = byte_end & (state_q == srp_pkg::SRP_DATA) & ~rd_q;
  logic srst;
  assign srst = wr_now & (addr_q == `SRP_CFG_ADDR) & in_byte[`SRP_CFG_SRST_BIT];

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_q <= `SRP_CFG_RESET;
    end else if (wr_now && addr_q == `SRP_CFG_ADDR) begin
      cfg_q <= in_byte;
    end
  end
  assign bidir_q     = cfg_q[`SRP_CFG_BIDIR_BIT];
  assign lsb_first_q = cfg_q[`SRP_CFG_LSBF_BIT];

  genvar gi;
  generate
    for (gi = 1; gi < NREG; gi++) begin : g_reg
      always_ff @(posedge clk) begin
        if (sys_rst || srst) begin
          regs_q[gi] <= `SRP_REG_RESET;
        end else if (wr_now && addr_q == 5'(gi)) begin
          regs_q[gi] <= in_byte;
        end
      end
    end
  endgenerate
  // Register 0 lives in cfg_q; this slot only keeps the read mux defined
  assign regs_q[0] = 8'h00;

  // Multiplier setting follows a clean config write (reset bit low)
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mult_cfg_q <= `SRP_CFG_RESET;
    end else if (wr_now && addr_q == `SRP_CFG_ADDR && !in_byte[`SRP_CFG_SRST_BIT]) begin
      mult_cfg_q <= in_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_view_q <= 8'h00;
    end else begin
      reg_view_q <= regs_q[1];
    end
  end

  // ============================================================
  // Read path: load at byte boundary, shift on falling edge
  logic [7:0] tx_q;
  logic       drive_q;
  logic       out_q;
  // Release follows select within three clocks of its rise
  always_ff @(posedge clk) begin
    if (sys_rst || sel_n) begin
      tx_q    <= 8'h00;
      drive_q <= 1'b0;
      out_q   <= 1'b0;
    end else if (fall) begin
      if (rd_q && state_q == srp_pkg::SRP_DATA) begin
        drive_q <= 1'b1;
        if (bit_q == 3'h0) begin
          out_q <= lsb_first_q ? out_byte[0] : out_byte[7];
          tx_q  <= lsb_first_q ? {1'b0, out_byte[7:1]} : {out_byte[6:0], 1'b0};
        end else begin
          out_q <= lsb_first_q ? tx_q[0] : tx_q[7];
          tx_q  <= lsb_first_q ? {1'b0, tx_q[7:1]} : {tx_q[6:0], 1'b0};
        end
      end else begin
        drive_q <= 1'b0;
      end
    end
  end

  assign link.sdio_dev_o             = out_q;
  assign link.sdio_dev_oe            = drive_q & bidir_q;
  assign link.serial_read_out_pin_o  = out_q;
  assign link.serial_read_out_pin_oe = drive_q & ~bidir_q;
endmodule

// file: inc/srp_regs.svh
/*
  Constants of the serial register port: instruction fields, register 00h
  bits, address width and the host clock divider.
  Assumes inclusion by both ends.
*/
`ifndef SRP_REGS_SVH
`define SRP_REGS_SVH
// ============================================================
// Instruction byte
`define SRP_INS_DIR_BIT    7
`define SRP_INS_CNT_HI     6
`define SRP_INS_CNT_LO     5
`define SRP_INS_ADR_HI     4
`define SRP_INS_ADR_LO     0
// ============================================================
// Register 00h
`define SRP_CFG_ADDR       5'h00
`define SRP_CFG_BIDIR_BIT  7
`define SRP_CFG_LSBF_BIT   6
`define SRP_CFG_SRST_BIT   5
`define SRP_CFG_RESET      8'h00
`define SRP_REG_RESET      8'h00
`define SRP_ADDR_MAX       5'h1F
// ============================================================
// Host timing: link clock max 15 MHz, sys clock 100 MHz
`define SRP_SYS_MHZ        100
`define SRP_LINK_MAX_MHZ   15
`define SRP_HALF_DIV       ((`SRP_SYS_MHZ + 2*`SRP_LINK_MAX_MHZ - 1) / (2*`SRP_LINK_MAX_MHZ))
`endif

// file: inc/srp_pkg.sv
/*
  Types shared by both ends of the serial register port.
  Assumes srp_regs.svh constants.
*/
package srp_pkg;
  typedef enum logic [2:0] {
    SRP_INS  = 3'h1,
    SRP_DATA = 3'h2,
    SRP_DONE = 3'h4
  } srp_dev_state_t;

  typedef enum logic [3:0] {
    SRP_H_IDLE = 4'h1,
    SRP_H_LOW  = 4'h2,
    SRP_H_HIGH = 4'h4,
    SRP_H_END  = 4'h8
  } srp_host_state_t;
endpackage

// file: inc/srp_if.sv
/*
  Serial link between host and device: clock, select, shared data pin and
  dedicated read pin. Resolves the shared pin from both enables.
  Assumes at most one driver at a time; undriven lines read high.
*/
`timescale 1ns/1ps
interface srp_if;
  logic sclk;
  logic sel_n;
  logic sdio_host_o;
  logic sdio_host_oe;
  logic sdio_dev_o;
  logic sdio_dev_oe;
  logic serial_read_out_pin_o;
  logic serial_read_out_pin_oe;
  logic sdio;
  logic serial_read_out_pin;

  assign sdio = sdio_host_oe ? sdio_host_o : (sdio_dev_oe ? sdio_dev_o : 1'b1);
  assign serial_read_out_pin = serial_read_out_pin_oe ? serial_read_out_pin_o : 1'b1;

  modport dev (
    input  sclk, sel_n, sdio,
    output sdio_dev_o, sdio_dev_oe, serial_read_out_pin_o, serial_read_out_pin_oe
  );
  modport host (
    input  sdio, serial_read_out_pin,
    output sclk, sel_n, sdio_host_o, sdio_host_oe
  );
endinterface

// file: rtl/srp_host.sv
/*
  Host end of the serial register port: runs one cycle per command,
  makes the link clock by dividing clk, captures read bytes.
  Assumes the device keeps its own rules; one command at a time.
*/
`timescale 1ns/1ps
`include "srp_regs.svh"
module srp_host #(
  parameter int HALF = `SRP_HALF_DIV
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  srp_if.host              link,
  input  wire logic        start,
  input  wire logic        rd,
  input  wire logic [1:0]  byte_count_field,
  input  wire logic [4:0]  start_address_field,
  input  wire logic [31:0] wdata,
  input  wire logic        lsb_first,
  input  wire logic        bidir,
  output logic             busy_q,
  output logic             done_q,
  output logic [31:0]      rdata_q
);
  srp_pkg::srp_host_state_t st_q;
  logic [3:0]  div_q;
  logic [5:0]  nbit_q;
  logic [5:0]  total_q;
  logic [39:0] tx_q;
  logic        lsbf_q, bidir_q2, rd_q;
  logic [1:0]  din_s_q;
  logic        sclk_q, sel_n_q, bit_out_q, oe_q;

  // Read line synchronised before use
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      din_s_q <= 2'h0;
    end else begin
      din_s_q <= {din_s_q[0], bidir_q2 ? link.sdio : link.serial_read_out_pin};
    end
  end

  function automatic logic [7:0] srp_ord(input logic [7:0] b, input logic l);
    srp_ord = b;
    if (l) begin
      for (int i = 0; i < 8; i++) begin
        srp_ord[i] = b[7-i];
      end
    end
  endfunction

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= srp_pkg::SRP_H_IDLE;
      div_q <= 4'h0;
      nbit_q <= 6'h00;
      total_q <= 6'h00;
      tx_q <= 40'h0;
      lsbf_q <= 1'b0;
      bidir_q2 <= 1'b0;
      rd_q <= 1'b0;
      sclk_q <= 1'b0;
      sel_n_q <= 1'b1;
      bit_out_q <= 1'b0;
      oe_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
      rdata_q <= 32'h0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        srp_pkg::SRP_H_IDLE: begin
          if (start) begin // left to software
            tx_q <= {srp_ord({rd, byte_count_field, start_address_field}, lsb_first),
                     srp_ord(wdata[31:24], lsb_first), srp_ord(wdata[23:16], lsb_first),
                     srp_ord(wdata[15:8], lsb_first), srp_ord(wdata[7:0], lsb_first)};
            total_q <= 6'((byte_count_field + 3'h2) * 8);
            lsbf_q <= lsb_first;
            bidir_q2 <= bidir;
            rd_q <= rd;
            nbit_q <= 6'h00;
            sel_n_q <= 1'b0;
            busy_q <= 1'b1;
            rdata_q <= 32'h0;
            div_q <= 4'h0;
            st_q <= srp_pkg::SRP_H_LOW;
          end
        end
        srp_pkg::SRP_H_LOW: begin // data set up while clock low
          sclk_q <= 1'b0;
          oe_q <= ~(rd_q && nbit_q >= 6'h08);
          bit_out_q <= tx_q[39];
          if (div_q == 4'(HALF - 1)) begin
            div_q <= 4'h0;
            st_q <= srp_pkg::SRP_H_HIGH;
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
        srp_pkg::SRP_H_HIGH: begin
          sclk_q <= 1'b1;
          if (div_q == 4'(HALF - 1)) begin
            div_q <= 4'h0;
            tx_q <= {tx_q[38:0], 1'b0};
            // Capture late in the high phase, past the synchroniser delay
            if (rd_q && nbit_q >= 6'h08) begin
              rdata_q <= {rdata_q[30:0], din_s_q[1]};
            end
            nbit_q <= nbit_q + 6'h01;
            st_q <= (nbit_q + 6'h01 == total_q) ? srp_pkg::SRP_H_END : srp_pkg::SRP_H_LOW;
          end else begin
            div_q <= div_q + 4'h1;
          end
        end
        srp_pkg::SRP_H_END: begin
          sclk_q <= 1'b0;
          // Capture ran in wire order; restore bit weights for LSB first
          if (lsbf_q) begin
            rdata_q <= {srp_ord(rdata_q[31:24], 1'b1), srp_ord(rdata_q[23:16], 1'b1),
                        srp_ord(rdata_q[15:8], 1'b1), srp_ord(rdata_q[7:0], 1'b1)};
          end
          oe_q <= 1'b0;
          sel_n_q <= 1'b1;
          busy_q <= 1'b0;
          done_q <= 1'b1;
          st_q <= srp_pkg::SRP_H_IDLE;
        end
        default: st_q <= srp_pkg::SRP_H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.sel_n = sel_n_q;
  assign link.sdio_host_o = bit_out_q;
  assign link.sdio_host_oe = oe_q;
endmodule

// file: test/srp_assertions.sv
/*
  Checker of the link joining host and device ends.
  Assumes plain link signals sampled by clk and a host half period of 4.
*/
`timescale 1ns/1ps
module srp_assertions (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic sel_n,
  input wire logic sdio_host_o,
  input wire logic sdio_host_oe,
  input wire logic sdio_dev_oe,
  input wire logic serial_read_out_pin_o,
  input wire logic serial_read_out_pin_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ==========================================================
  // Link rules
  // Six cycles leave room for the three-stage sampling
  a_sel_high_quiet: assert property (sel_n [*6] |-> !sdio_dev_oe && !serial_read_out_pin_oe)
    else $error("device drives while deselected");
  a_ins_phase_quiet: assert property ($fell(sel_n) |-> ##6 (!sdio_dev_oe && !serial_read_out_pin_oe) [*8])
    else $error("device drives during instruction");
  a_sclk_high_time: assert property ($rose(sclk) |-> sclk [*4] ##1 !sclk)
    else $error("link clock high phase wrong");
  a_sclk_low_time: assert property ($fell(sclk) && !sel_n |-> !sclk [*4])
    else $error("link clock low phase short");
  a_host_data_set: assert property ($rose(sclk) && sdio_host_oe |-> $stable(sdio_host_o))
    else $error("host data moves at rising edge");
  a_dev_out_hold: assert property (sclk && $past(sclk) && serial_read_out_pin_oe && $past(serial_read_out_pin_oe) |-> $stable(serial_read_out_pin_o))
    else $error("read data moves while clock high");
  a_no_contention: assert property (!(sdio_host_oe && sdio_dev_oe))
    else $error("both ends drive shared pin");
  a_one_read_pin: assert property (!(sdio_dev_oe && serial_read_out_pin_oe))
    else $error("read data on both pins");
  a_sclk_idle: assert property (sel_n && $past(sel_n) |-> $stable(sclk))
    else $error("link clock toggles while deselected");
  a_frame_bounded: assert property ($fell(sel_n) |-> ##[124:340] $rose(sel_n))
    else $error("frame length out of range");
  c_frame: cover property ($fell(sel_n));
  c_two_pin_read: cover property (serial_read_out_pin_oe);
  c_shared_read: cover property (sdio_dev_oe);
endmodule

// file: test/tb_serial_register_port.sv
/*
  Self-checking bench: host and device joined by one link, a second
  device driven bit by bit from the bench for abort cases.
  Assumes host half period 4, clk 100 MHz.
*/
`timescale 1ns/1ps
module tb_serial_register_port;
  logic        clk;
  logic        sys_rst;
  logic        start;
  logic        rd;
  logic [1:0]  cnt;
  logic [4:0]  adr;
  logic [31:0] wdata;
  logic        lsbf;
  logic        bidir;
  logic        busy_q;
  logic        done_q;
  logic [31:0] rdata_q;
  logic [7:0]  mult_cfg_q;
  logic [7:0]  reg_view_q;
  logic [7:0]  view2;
  logic        bidir_q;
  logic        lsb_first_q;
  logic [7:0]  mdl [32];
  logic        m_lsbf;
  logic        m_bidir;
  logic [7:0]  m_mult;
  logic [7:0]  ins_sh;
  logic        sclk_d;
  logic [31:0] seed;
  int          ins_bits = 0;
  int          pin_misuse = 0;
  int          cyc = 0;
  int          error_cnt = 0;
  int          n_compared = 0;

  srp_if link ();
  srp_if link2 ();
  srp_device srp_device_i (.clk(clk), .sys_rst(sys_rst), .link(link), .mult_cfg_q(mult_cfg_q),
    .bidir_q(bidir_q), .lsb_first_q(lsb_first_q), .reg_view_q(reg_view_q));
  srp_device srp_device_abort_i (.clk(clk), .sys_rst(sys_rst), .link(link2), .mult_cfg_q(),
    .bidir_q(), .lsb_first_q(), .reg_view_q(view2));
  srp_host #(.HALF(4)) srp_host_i (.clk(clk), .sys_rst(sys_rst), .link(link), .start(start),
    .rd(rd), .byte_count_field(cnt), .start_address_field(adr), .wdata(wdata),
    .lsb_first(lsbf), .bidir(bidir), .busy_q(busy_q), .done_q(done_q), .rdata_q(rdata_q));
  srp_assertions srp_assertions_i (.clk(clk), .sys_rst(sys_rst), .sclk(link.sclk),
    .sel_n(link.sel_n), .sdio_host_o(link.sdio_host_o), .sdio_host_oe(link.sdio_host_oe),
    .sdio_dev_oe(link.sdio_dev_oe), .serial_read_out_pin_o(link.serial_read_out_pin_o),
    .serial_read_out_pin_oe(link.serial_read_out_pin_oe));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Wire monitor and hang guard
  always @(posedge clk) begin
    sclk_d <= link.sclk;
    cyc <= cyc + 1;
    if (link.sel_n) ins_bits <= 0;
    else if (link.sclk && !sclk_d && ins_bits < 8) begin
      ins_sh <= {ins_sh[6:0], link.sdio};
      ins_bits <= ins_bits + 1;
    end
    if (m_bidir && link.serial_read_out_pin_oe) pin_misuse <= pin_misuse + 1;
    if (cyc == 40000) begin
      error_cnt++;
      tally_and_finish();
    end
  end
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s exp %h got %h", what, exp, got);
    end
  endtask

  // One host cycle; the model follows config changes byte by byte
  task automatic xfer(logic r, logic [1:0] n, logic [4:0] a, logic [31:0] w);
    logic [31:0] exp;
    logic [31:0] mask;
    logic [7:0]  b;
    int          k;
    exp = 32'h0;
    mask = 32'h0;
    k = 0;
    repeat (4) @(posedge clk);
    start <= 1'b1; rd <= r; cnt <= n; adr <= a; wdata <= w; lsbf <= m_lsbf; bidir <= m_bidir;
    @(posedge clk);
    start <= 1'b0;
    while (done_q !== 1'b1 && k < 1000) begin
      @(posedge clk);
      k++;
    end
    chk("done", 32'h1, {31'h0, done_q});
    b = {r, n, a};
    if (m_lsbf) b = {<<{b}};
    chk("instruction on wire", {24'h0, b}, {24'h0, ins_sh});
    for (int i = 0; i <= n; i++) begin
      b = w[31 - 8 * i -: 8];
      if (r) begin
        exp = {exp[23:0], mdl[a]};
        mask = {mask[23:0], 8'hFF};
      end else begin
        mdl[a] = b;
        if (a == 5'h00) begin
          if (b[5]) for (int j = 1; j < 32; j++) mdl[j] = 8'h00;
          else m_mult = b;
          m_lsbf = b[6];
          m_bidir = b[7];
        end
      end
      a = m_lsbf ? a + 5'h01 : a - 5'h01;
    end
    if (r) chk("read data", exp, rdata_q & mask);
    chk("config", {14'h0, m_bidir, m_lsbf, m_mult, mdl[1]},
        {14'h0, bidir_q, lsb_first_q, mult_cfg_q, reg_view_q});
  endtask

  // Bench plays host on the second link, MSB first, 80 ns clock
  task automatic bang(logic [15:0] v, int nb);
    for (int i = 0; i < nb; i++) begin
      @(posedge clk);
      link2.sdio_host_o <= v[15 - i];
      link2.sclk <= 1'b0;
      repeat (4) @(posedge clk);
      link2.sclk <= 1'b1;
      repeat (3) @(posedge clk);
    end
    @(posedge clk);
    link2.sclk <= 1'b0;
  endtask

  task automatic sel2(logic v);
    @(posedge clk);
    link2.sel_n <= v;
    repeat (8) @(posedge clk);
  endtask

  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    logic [31:0] rw;
    logic [4:0]  ra;
    logic [1:0]  rn;
    seed = 32'hB9A131F1;
    sys_rst = 1'b1; start = 1'b0; rd = 1'b0; cnt = 2'h0; adr = 5'h00; wdata = 32'h0;
    lsbf = 1'b0; bidir = 1'b0; m_lsbf = 1'b0; m_bidir = 1'b0; m_mult = 8'h00;
    link2.sclk = 1'b0; link2.sel_n = 1'b1; link2.sdio_host_o = 1'b1; link2.sdio_host_oe = 1'b1;
    for (int j = 0; j < 32; j++) mdl[j] = 8'h00;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    xfer(1'b1, 2'h3, 5'h03, 32'h0);
    // Start at 5 or above so a decrementing run never reaches register 0
    repeat (12) begin
      rw = xs();
      rn = rw[1:0];
      ra = 5'h05 + 5'(rw[9:2] % 8'h1B);
      rw = xs();
      xfer(1'b0, rn, ra, rw);
      xfer(1'b1, rn, ra, 32'h0);
    end
    xfer(1'b0, 2'h1, 5'h00, {8'h00, rw[7:0], 16'h0});
    xfer(1'b1, 2'h0, 5'h1F, 32'h0);
    xfer(1'b0, 2'h0, 5'h00, 32'hC0000000);
    xfer(1'b0, 2'h1, 5'h1F, {rw[31:24], 8'hC0, 16'h0});
    xfer(1'b1, 2'h2, 5'h1E, 32'h0);
    xfer(1'b0, 2'h3, 5'h01, rw);
    xfer(1'b0, 2'h0, 5'h00, 32'hE7000000);
    xfer(1'b1, 2'h3, 5'h01, 32'h0);
    xfer(1'b0, 2'h0, 5'h00, 32'hC2000000);
    xfer(1'b0, 2'h0, 5'h00, 32'h80000000);
    xfer(1'b1, 2'h1, 5'h1F, 32'h0);
    xfer(1'b0, 2'h0, 5'h00, 32'h00000000);
    xfer(1'b1, 2'h1, 5'h1F, 32'h0);
    chk("dedicated pin in shared mode", 32'h0, 32'(pin_misuse));
    bang(16'hFFFF, 8);
    sel2(1'b0);
    bang({8'h01, 8'hF0}, 12);
    sel2(1'b1);
    sel2(1'b0);
    bang({8'h01, 8'h3C}, 16);
    sel2(1'b1);
    chk("abort recovery", 32'h3C, {24'h0, view2});
    tally_and_finish();
  end
endmodule
